// *** countdown_timer_pkg.sv ***
// constants, enums and structs of the cascadable countdown timer
package countdown_timer_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_CONTROL     = 10'h01e;
  localparam logic [9:0] IDX_RELOAD_HIGH = 10'h01f;
  localparam logic [9:0] IDX_RELOAD_LOW  = 10'h020;
  localparam logic [9:0] IDX_COUNT_HIGH  = 10'h021;
  localparam logic [9:0] IDX_COUNT_LOW   = 10'h022;
  localparam logic [9:0] IDX_IRQ_STATUS  = 10'h030;
  localparam logic [9:0] IDX_IRQ_MASK    = 10'h031;
  localparam logic [9:0] IDX_COMMAND     = 10'h032;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         CTL_STOP_RX_BIT = 7;
  localparam int         CTL_START_LSB   = 4;
  localparam int         CTL_RESTART_BIT = 3;
  localparam int         CTL_SRC_LSB     = 0;
  localparam logic [7:0] CTL_WRITE_MASK  = 8'hbb;
  localparam logic [7:0] CTL_RESET       = 8'h00;
  localparam logic [7:0] RELOAD_RESET    = 8'h00;
  localparam int         IRQ_W           = 2;
  localparam int         IRQ_UFLOW_BIT   = 0;
  localparam int         IRQ_TRIM_BIT    = 1;
  localparam logic [1:0] IRQ_RESET       = 2'h0;
  localparam int         CMD_START_BIT   = 0;
  localparam int         CMD_STOP_BIT    = 1;
  localparam int         CMD_RUNNING_BIT = 0;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    START_NONE     = 2'b00,
    START_TX_END   = 2'b01,
    TRIM_NO_UFLOW  = 2'b10,
    TRIM_UFLOW     = 2'b11
  } start_mode_e;

  typedef enum logic [1:0] {
    SRC_FAST    = 2'b00,
    SRC_BITRATE = 2'b01,
    SRC_SIB0    = 2'b10,
    SRC_SIB1    = 2'b11
  } source_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN   = 2'b10
  } state_e;

  // ---------------------------------------------------------------
  // structs
  // ---------------------------------------------------------------
  typedef struct packed {
    logic tx_end;
    logic rx_first_bits;
    logic tick_fast;
    logic tick_bitrate;
    logic sib0_uflow;
    logic sib1_uflow;
    logic trim_edge;
  } events_s;

  typedef struct packed {
    state_e           state;
    logic [7:0]       control;
    logic [7:0]       reload_hi;
    logic [7:0]       reload_lo;
    logic [15:0]      count;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0]      prdata;
    logic             pslverr;
    logic             underflow;
  } state_s;

  localparam state_s STATE_RESET = '0;

endpackage : countdown_timer_pkg

// *** cascadable_countdown_timer.sv ***
// cascadable 16-bit countdown timer with apb registers and interrupt
//
// Overview of operation
// - with stop_on_receive set, the timer halts at once when the first 4 received bits are in.
// - stop_on_receive has no effect while a trimming mode is selected.
// - auto_start_select 00b never starts the timer from a transmission event.
// - auto_start_select 01b loads the reload value and starts at end of transmission.
// - codes 10b and 11b trim the oscillator between positive edges, 10b without underflow.
// - with reload_on_underflow set, the counter reloads and keeps counting at zero, except in trim mode 10b, where it stops at zero.
// - with reload_on_underflow clear, the counter stops at zero until a new start.
// - every underflow sets the underflow_flag.
// - source 00b counts the fast clock ticks and 01b the bit-rate clock ticks.
// - source 10b counts first sibling underflows and 11b second sibling underflows.
// - each start event loads the counter with the 16-bit reload value.
// - reload byte writes do not touch a running count, only the next start or underflow reload.
// - the live count reads as a read-only high byte and low byte.
`timescale 1ns/1ps

module cascadable_countdown_timer (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst,
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [11:0]                  i_paddr,
  input  wire logic [31:0]                  i_pwdata,
  input  wire logic [3:0]                   i_pstrb,
  output logic      [31:0]                  o_prdata,
  output logic                              o_pready,
  output logic                              o_pslverr,
  input  wire countdown_timer_pkg::events_s i_events,
  output logic                              o_underflow,
  output logic                              o_running,
  output logic                              o_irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  countdown_timer_pkg::state_s s_reg;
  countdown_timer_pkg::state_s s_next;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // word-aligned hit on a register index
  function automatic logic reg_hit(
    input logic [11:0] addr,
    input logic [9:0]  idx
  );
    reg_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : reg_hit

  function automatic logic mapped(input logic [11:0] addr);
    mapped = reg_hit(addr, countdown_timer_pkg::IDX_CONTROL)
           | reg_hit(addr, countdown_timer_pkg::IDX_RELOAD_HIGH)
           | reg_hit(addr, countdown_timer_pkg::IDX_RELOAD_LOW)
           | reg_hit(addr, countdown_timer_pkg::IDX_COUNT_HIGH)
           | reg_hit(addr, countdown_timer_pkg::IDX_COUNT_LOW)
           | reg_hit(addr, countdown_timer_pkg::IDX_IRQ_STATUS)
           | reg_hit(addr, countdown_timer_pkg::IDX_IRQ_MASK)
           | reg_hit(addr, countdown_timer_pkg::IDX_COMMAND);
  endfunction : mapped

  // ---------------------------------------------------------------
  // combinational next state
  // ---------------------------------------------------------------
  countdown_timer_pkg::start_mode_e mode;
  countdown_timer_pkg::source_e     src;
  logic                             trim;
  logic                             tick;
  logic                             wr;
  logic                             setup;
  logic                             sw_start;
  logic                             sw_stop;
  logic [15:0]                      reload_value;
  logic [countdown_timer_pkg::IRQ_W-1:0] irq_set;
  logic [countdown_timer_pkg::IRQ_W-1:0] irq_clr;
  logic [7:0]                       rbyte;

  always_comb begin
    s_next       = s_reg;
    s_next.underflow = 1'b0;
    irq_set      = '0;
    irq_clr      = '0;
    rbyte        = 8'h00;
    mode         = countdown_timer_pkg::start_mode_e'(
                     s_reg.control[countdown_timer_pkg::CTL_START_LSB +: 2]);
    src          = countdown_timer_pkg::source_e'(
                     s_reg.control[countdown_timer_pkg::CTL_SRC_LSB +: 2]);
    trim         = (mode == countdown_timer_pkg::TRIM_NO_UFLOW)
                 | (mode == countdown_timer_pkg::TRIM_UFLOW);
    reload_value = {s_reg.reload_hi, s_reg.reload_lo};
    // writes commit only in the access cycle, on lane 0
    wr    = i_psel & i_penable & i_pwrite & i_pstrb[0];
    setup = i_psel & ~i_penable;
    sw_start = wr & reg_hit(i_paddr, countdown_timer_pkg::IDX_COMMAND)
             & i_pwdata[countdown_timer_pkg::CMD_START_BIT];
    sw_stop  = wr & reg_hit(i_paddr, countdown_timer_pkg::IDX_COMMAND)
             & i_pwdata[countdown_timer_pkg::CMD_STOP_BIT];

    // count source selection
    case (src)
      countdown_timer_pkg::SRC_FAST:    tick = i_events.tick_fast;
      countdown_timer_pkg::SRC_BITRATE: tick = i_events.tick_bitrate;
      countdown_timer_pkg::SRC_SIB0:    tick = i_events.sib0_uflow;
      countdown_timer_pkg::SRC_SIB1:    tick = i_events.sib1_uflow;
      default:                          tick = 1'b0;
    endcase

    // -------------------------------------------------------------
    // timer sequencing
    // -------------------------------------------------------------
    case (s_reg.state)
      countdown_timer_pkg::ST_IDLE: begin
        if (sw_start) begin
          if (trim) begin
            // trimming waits for the first positive edge
            s_next.state = countdown_timer_pkg::ST_ARMED;
          end else begin
            s_next.count = reload_value;
            s_next.state = countdown_timer_pkg::ST_RUN;
          end
        end else if ((mode == countdown_timer_pkg::START_TX_END)
                     && i_events.tx_end) begin
          // only code 01b reacts to tx_end
          s_next.count = reload_value;
          s_next.state = countdown_timer_pkg::ST_RUN;
        end
      end

      countdown_timer_pkg::ST_ARMED: begin
        if (sw_stop || !trim) begin
          s_next.state = countdown_timer_pkg::ST_IDLE;
        end else if (i_events.trim_edge) begin
          s_next.count = reload_value;
          s_next.state = countdown_timer_pkg::ST_RUN;
        end
      end

      countdown_timer_pkg::ST_RUN: begin
        if (sw_stop) begin
          s_next.state = countdown_timer_pkg::ST_IDLE;
        end else if (trim && i_events.trim_edge) begin
          // second edge ends the measurement, count is kept
          s_next.state = countdown_timer_pkg::ST_IDLE;
          irq_set[countdown_timer_pkg::IRQ_TRIM_BIT] = 1'b1;
        end else if (!trim
                     && s_reg.control[countdown_timer_pkg::CTL_STOP_RX_BIT]
                     && i_events.rx_first_bits) begin
          // trimming masks the receive stop
          s_next.state = countdown_timer_pkg::ST_IDLE;
        end else if (tick) begin
          if (s_reg.count != 16'h0000) begin
            s_next.count = s_reg.count - 16'h0001;
          end else if (mode == countdown_timer_pkg::TRIM_NO_UFLOW) begin
            // no underflow allowed: stop at zero silently
            s_next.state = countdown_timer_pkg::ST_IDLE;
          end else begin
            s_next.underflow = 1'b1;
            irq_set[countdown_timer_pkg::IRQ_UFLOW_BIT] = 1'b1;
            if (s_reg.control[countdown_timer_pkg::CTL_RESTART_BIT]) begin
              s_next.count = reload_value;
            end else begin
              s_next.state = countdown_timer_pkg::ST_IDLE;
            end
          end
        end
      end

      default: begin
        s_next.state = countdown_timer_pkg::ST_IDLE;
      end
    endcase

    // -------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------
    if (wr && reg_hit(i_paddr, countdown_timer_pkg::IDX_CONTROL)) begin
      s_next.control = i_pwdata[7:0] & countdown_timer_pkg::CTL_WRITE_MASK;
    end
    // reload bytes are only sampled at a start event or an underflow reload
    if (wr && reg_hit(i_paddr, countdown_timer_pkg::IDX_RELOAD_HIGH)) begin
      s_next.reload_hi = i_pwdata[7:0];
    end
    if (wr && reg_hit(i_paddr, countdown_timer_pkg::IDX_RELOAD_LOW)) begin
      s_next.reload_lo = i_pwdata[7:0];
    end
    if (wr && reg_hit(i_paddr, countdown_timer_pkg::IDX_IRQ_MASK)) begin
      s_next.irq_mask = i_pwdata[countdown_timer_pkg::IRQ_W-1:0];
    end
    if (wr && reg_hit(i_paddr, countdown_timer_pkg::IDX_IRQ_STATUS)) begin
      irq_clr = i_pwdata[countdown_timer_pkg::IRQ_W-1:0];
    end
    // set wins over a write-one clear in the same cycle
    s_next.irq_status = (s_reg.irq_status & ~irq_clr) | irq_set;

    // -------------------------------------------------------------
    // read data, captured in the setup cycle
    // -------------------------------------------------------------
    if (setup) begin
      if (reg_hit(i_paddr, countdown_timer_pkg::IDX_CONTROL)) begin
        rbyte = s_reg.control;
      end else if (reg_hit(i_paddr, countdown_timer_pkg::IDX_RELOAD_HIGH)) begin
        rbyte = s_reg.reload_hi;
      end else if (reg_hit(i_paddr, countdown_timer_pkg::IDX_RELOAD_LOW)) begin
        rbyte = s_reg.reload_lo;
      end else if (reg_hit(i_paddr, countdown_timer_pkg::IDX_COUNT_HIGH)) begin
        // not coherent with the low byte while counting
        rbyte = s_reg.count[15:8];
      end else if (reg_hit(i_paddr, countdown_timer_pkg::IDX_COUNT_LOW)) begin
        rbyte = s_reg.count[7:0];
      end else if (reg_hit(i_paddr, countdown_timer_pkg::IDX_IRQ_STATUS)) begin
        rbyte = {6'h00, s_reg.irq_status};
      end else if (reg_hit(i_paddr, countdown_timer_pkg::IDX_IRQ_MASK)) begin
        rbyte = {6'h00, s_reg.irq_mask};
      end else if (reg_hit(i_paddr, countdown_timer_pkg::IDX_COMMAND)) begin
        rbyte = {7'h00, (s_reg.state != countdown_timer_pkg::ST_IDLE)};
      end
      s_next.prdata  = {24'h000000, rbyte};
      s_next.pslverr = ~mapped(i_paddr);
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= countdown_timer_pkg::STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // zero wait states: data was captured during setup
  assign o_pready    = 1'b1;
  assign o_prdata    = s_reg.prdata;
  assign o_pslverr   = s_reg.pslverr & i_psel & i_penable;
  assign o_underflow = s_reg.underflow;
  assign o_running   = (s_reg.state != countdown_timer_pkg::ST_IDLE);
  assign o_irq       = |(s_reg.irq_status & s_reg.irq_mask);

endmodule : cascadable_countdown_timer

// *** cascadable_countdown_timer_checker.sv ***
// port-level assertions for the countdown timer
`timescale 1ns/1ps

module cascadable_countdown_timer_checker (
  input wire logic                         i_mclk,
  input wire logic                         i_rst,
  input wire logic                         i_psel,
  input wire logic                         i_penable,
  input wire logic                         i_pwrite,
  input wire logic [11:0]                  i_paddr,
  input wire logic [31:0]                  i_pwdata,
  input wire logic [3:0]                   i_pstrb,
  input wire logic [31:0]                  o_prdata,
  input wire logic                         o_pready,
  input wire logic                         o_pslverr,
  input wire countdown_timer_pkg::events_s i_events,
  input wire logic                         o_underflow,
  input wire logic                         o_running,
  input wire logic                         o_irq
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic tick_any;
  logic wr_any;
  assign tick_any = i_events.tick_fast | i_events.tick_bitrate | i_events.sib0_uflow
                  | i_events.sib1_uflow;
  assign wr_any = i_psel & i_penable & i_pwrite;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_setup; i_psel && !i_penable; endsequence
  sequence s_access; i_psel && i_penable; endsequence

  AST_ACCESS_DONE: assert property (s_setup ##1 s_access |-> o_pready)
    else $error("access phase not answered");
  AST_RDATA_UPPER: assert property (o_prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_RDATA_HOLD: assert property (!$past(i_psel && !i_penable) |-> $stable(o_prdata))
    else $error("read data moved outside setup");
  AST_ERR_ACCESS: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("error response outside access");
  AST_UF_RUN: assert property (o_underflow |-> $past(o_running))
    else $error("underflow while stopped");
  AST_UF_TICK: assert property (o_underflow |-> $past(tick_any))
    else $error("underflow without count tick");
  AST_START: assert property ($rose(o_running) |-> $past(i_events.tx_end | wr_any))
    else $error("timer started without cause");
  AST_STOP: assert property ($fell(o_running) |->
    $past(tick_any | i_events.rx_first_bits | i_events.trim_edge | wr_any))
    else $error("timer stopped without cause");
endmodule : cascadable_countdown_timer_checker

// *** test_cascadable_countdown_timer.sv ***
// self-checking bench for the countdown timer
`timescale 1ns/1ps

module test_cascadable_countdown_timer;
  logic                         i_mclk, i_rst, i_psel, i_penable, i_pwrite;
  logic [11:0]                  i_paddr;
  logic [31:0]                  i_pwdata, o_prdata, rd;
  logic [3:0]                   i_pstrb;
  logic                         o_pready, o_pslverr, o_underflow, o_running, o_irq, uf, err;
  countdown_timer_pkg::events_s i_events;
  int                           n_fail, num_checks, s;

  cascadable_countdown_timer cascadable_countdown_timer_i (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_events(i_events),
    .o_underflow(o_underflow), .o_running(o_running), .o_irq(o_irq));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int k;
    @(posedge i_mclk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= {idx, 2'b00};
    i_pwdata  <= {24'h0, d};
    @(posedge i_mclk);
    i_penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge i_mclk);
      if (o_pready === 1'b1) break;
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    if (k == 16) begin
      n_fail++;
      report_and_stop();
    end
  endtask : apb

  // count reads are only issued while no reception is in progress
  task rchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask : rchk

  // one-cycle event pulse; uf holds the underflow pulse that follows it
  task pulse(input logic [6:0] e);
    @(posedge i_mclk);
    i_events <= e;
    @(posedge i_mclk);
    i_events <= '0;
    // sampled mid-cycle: the pulse register changes on the next edge
    @(negedge i_mclk);
    uf = o_underflow;
    @(posedge i_mclk);
  endtask : pulse

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    rchk(countdown_timer_pkg::IDX_CONTROL, 32'h0);
    rchk(countdown_timer_pkg::IDX_COUNT_HIGH, 32'h0);
    apb(1'b1, countdown_timer_pkg::IDX_CONTROL, 8'hff);
    rchk(countdown_timer_pkg::IDX_CONTROL, 32'hbb);
    apb(1'b0, 10'h3ff, 8'h00);
    check(err, 32'h1);
  endtask : t_reset

  task t_txstart;
    apb(1'b1, countdown_timer_pkg::IDX_CONTROL, 8'h00);
    apb(1'b1, countdown_timer_pkg::IDX_RELOAD_LOW, 8'h02);
    apb(1'b1, countdown_timer_pkg::IDX_IRQ_MASK, 8'h01);
    pulse(7'h40);
    check(o_running, 32'h0);
    apb(1'b1, countdown_timer_pkg::IDX_CONTROL, 8'h10);
    pulse(7'h40);
    check(o_running, 32'h1);
    rchk(countdown_timer_pkg::IDX_COUNT_LOW, 32'h2);
    pulse(7'h10);
    pulse(7'h10);
    check(uf, 32'h0);
    rchk(countdown_timer_pkg::IDX_COUNT_LOW, 32'h0);
    pulse(7'h10);
    check(uf, 32'h1);
    check(o_running, 32'h0);
    rchk(countdown_timer_pkg::IDX_IRQ_STATUS, 32'h1);
    check(o_irq, 32'h1);
    apb(1'b1, countdown_timer_pkg::IDX_IRQ_STATUS, 8'h01);
    rchk(countdown_timer_pkg::IDX_IRQ_STATUS, 32'h0);
    check(o_irq, 32'h0);
  endtask : t_txstart

  task t_restart;
    apb(1'b1, countdown_timer_pkg::IDX_CONTROL, 8'h08);
    apb(1'b1, countdown_timer_pkg::IDX_RELOAD_LOW, 8'h01);
    apb(1'b1, countdown_timer_pkg::IDX_COMMAND, 8'h01);
    pulse(7'h10);
    pulse(7'h10);
    check(uf, 32'h1);
    check(o_running, 32'h1);
    apb(1'b1, countdown_timer_pkg::IDX_RELOAD_LOW, 8'h07);
    rchk(countdown_timer_pkg::IDX_COUNT_LOW, 32'h1);
    apb(1'b1, countdown_timer_pkg::IDX_COMMAND, 8'h02);
    rchk(countdown_timer_pkg::IDX_COMMAND, 32'h0);
  endtask : t_restart

  // other sources must not move the count, the selected one must
  task t_source;
    for (s = 0; s < 4; s++) begin
      apb(1'b1, countdown_timer_pkg::IDX_CONTROL, 8'(s));
      apb(1'b1, countdown_timer_pkg::IDX_RELOAD_LOW, 8'h05);
      apb(1'b1, countdown_timer_pkg::IDX_COMMAND, 8'h01);
      pulse(7'h1e & ~(7'h10 >> s));
      rchk(countdown_timer_pkg::IDX_COUNT_LOW, 32'h5);
      pulse(7'h10 >> s);
      rchk(countdown_timer_pkg::IDX_COUNT_LOW, 32'h4);
      apb(1'b1, countdown_timer_pkg::IDX_COMMAND, 8'h02);
    end
  endtask : t_source

  task t_receive;
    apb(1'b1, countdown_timer_pkg::IDX_CONTROL, 8'h80);
    apb(1'b1, countdown_timer_pkg::IDX_COMMAND, 8'h01);
    pulse(7'h20);
    check(o_running, 32'h0);
    apb(1'b1, countdown_timer_pkg::IDX_CONTROL, 8'hb0);
    apb(1'b1, countdown_timer_pkg::IDX_RELOAD_LOW, 8'h00);
    apb(1'b1, countdown_timer_pkg::IDX_COMMAND, 8'h01);
    pulse(7'h01);
    pulse(7'h20);
    check(o_running, 32'h1);
    pulse(7'h01);
    check(o_running, 32'h0);
    rchk(countdown_timer_pkg::IDX_IRQ_STATUS, 32'h3);
    apb(1'b1, countdown_timer_pkg::IDX_CONTROL, 8'h20);
    apb(1'b1, countdown_timer_pkg::IDX_COMMAND, 8'h01);
    pulse(7'h01);
    pulse(7'h10);
    check(uf, 32'h0);
    check(o_running, 32'h0);
  endtask : t_receive

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  initial begin
    i_rst = 1'b1;
    {i_psel, i_penable, i_pwrite} = 3'h0;
    i_paddr = 12'h0;
    i_pwdata = 32'h0;
    i_pstrb = 4'hf;
    i_events = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset;
    t_txstart;
    t_restart;
    t_source;
    t_receive;
    report_and_stop();
  end
endmodule : test_cascadable_countdown_timer

bind cascadable_countdown_timer cascadable_countdown_timer_checker
  cascadable_countdown_timer_checker_i (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_events(i_events),
  .o_underflow(o_underflow), .o_running(o_running), .o_irq(o_irq));
